/* cic_core_irq_ctrl.sv */
/*
 * Core interrupt control register logic behind an APB slave.
 * Holds the global and peripheral enables, the three core source
 * enable/flag pairs, the per-pin change flags that feed the summary
 * flag, and a sticky event status register with mask and irq output.
 * Register map, one aligned 32-bit word each, bits 7:0 used (3:0 in status and mask):
 *   0x000 interrupt_control, 0x004 per-pin change flags (write 1 clears),
 *   0x008 sticky event status (write 1 clears), 0x00c event mask.
 * Core request and irq are registered and follow their causes one cycle
 * later; read data is taken in the setup phase, with no wait state.
 * Assumes: timer overflow and peripheral pending come from logic on
 * clock; the external pin and pin-change pins are asynchronous.
 * Pin edges in the first cycles after reset are not reported: the
 * synchronisers refill from zero and the level found then is the baseline.
 */
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps

// Contract
// - With the global enable set any individually enabled source may request, else none.
// - Peripheral requests pass only while the peripheral enable is set.
// - The timer overflow request passes only while its enable is set.
// - The external pin request passes only while its enable is set.
// - The pin-change request passes only while its enable is set.
// - The timer overflow flag sets on overflow and stays clear until one occurs; here a bus write of 1 to its bit also sets it.
// - The external pin flag sets on a pin event and stays clear until one occurs; here a bus write of 1 to its bit also sets it.
// - The pin-change summary flag is one while any per-pin change flag is set.
// - The summary flag ignores writes and clears only when all per-pin flags are cleared.
// - Every flag sets on its event regardless of its enable and the global enable.
module cic_core_irq_ctrl (
    input  wire logic                  clock,
    input  wire logic                  reset_n,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic      [31:0]           prdata,
    output logic                       pslverr,
    // event sources
    input  cic_pkg::cic_src_s          src_in,
    input  wire logic                  external_irq_pin,
    input  wire logic [7:0]            pin_change_pins,
    // requests
    output logic                       core_irq_req,
    output cic_pkg::cic_ctrl_s         ctrl_out,
    output logic                       irq
);
    import cic_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    cic_ctrl_s        ctrl_q;          // writable fields; summary bit unused
    cic_ctrl_s        ctrl_d;
    cic_ctrl_s        ctrl_view;       // what software reads
    logic [7:0]       pc_flags_q;
    logic [7:0]       pc_flags_d;
    logic [3:0]       evt_stat_q;
    logic [3:0]       evt_stat_d;
    logic [3:0]       evt_mask_q;
    logic [3:0]       evt_mask_d;
    logic [31:0]      prdata_q;
    logic [31:0]      prdata_d;
    logic             core_irq_q;
    logic             core_irq_d;
    logic             irq_q;
    logic             irq_d;
    logic             peri_prev_q;
    logic [1:0]       warm_q;          // edges since reset, saturating
    logic [1:0]       warm_d;

    // synchronised pins
    logic             ext_rise;
    logic [7:0]       pc_rise;
    logic [7:0]       pc_fall;
    logic [7:0]       pc_edge;

    // bus decode
    logic             setup_ph;
    logic             access_ph;
    logic             hit_ctrl;
    logic             hit_pc;
    logic             hit_stat;
    logic             hit_mask;
    logic             hit_any;
    logic             wr_lane0;
    logic             wr_ctrl;
    logic             wr_pc;
    logic             wr_stat;
    logic             wr_mask;
    logic [7:0]       wbyte;

    // flag logic
    logic             summary;
    logic             tof_set;
    logic             exf_set;
    logic             peri_rise;
    logic [3:0]       evt_set;
    logic [3:0]       evt_clr;
    logic [7:0]       pc_clr;
    logic             warm_done;
    logic             req_tmr;
    logic             req_ext;
    logic             req_pc;
    logic             req_peri;
    logic             core_src_any;

    // read path
    logic [31:0]      rd_ctrl;
    logic [31:0]      rd_pc;
    logic [31:0]      rd_stat;
    logic [31:0]      rd_mask;
    logic [31:0]      rd_word;

    // edges count once the synchronisers hold real pin samples
    localparam logic [1:0] CIC_WARM_DONE = 2'(CIC_SYNC_STAGES + 1);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    // external interrupt pin, rising edge is the event
    cic_pin_sync #(
        .WIDTH   (1)
    ) u_ext_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .pin     (external_irq_pin),
        .level   (),
        .rise    (ext_rise),
        .fall    ()
    );

    // pin-change inputs, either edge is a change
    cic_pin_sync #(
        .WIDTH   (CIC_PC_PINS)
    ) u_pc_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .pin     (pin_change_pins),
        .level   (),
        .rise    (pc_rise),
        .fall    (pc_fall)
    );

    // a pin already high at reset would look like a rise while the chain
    // refills, so edges are ignored until it holds real samples
    assign warm_done = (warm_q == CIC_WARM_DONE);
    assign warm_d    = warm_done ? warm_q : warm_q + 2'h1;

    assign pc_edge   = (pc_rise | pc_fall) & {CIC_PC_PINS{warm_done}};

    ////////////////////////////////////////////////////////////////////////
    // apb decode

    // setup samples read data, access completes with no wait state
    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;

    assign hit_ctrl  = (paddr == CIC_OFF_CTRL);
    assign hit_pc    = (paddr == CIC_OFF_PC_FLAGS);
    assign hit_stat  = (paddr == CIC_OFF_EVT_STAT);
    assign hit_mask  = (paddr == CIC_OFF_EVT_MASK);
    assign hit_any   = hit_ctrl | hit_pc | hit_stat | hit_mask;

    // only byte lane 0 carries register bits; a write without it, or to an
    // unmapped address, changes nothing
    assign wr_lane0  = access_ph & pwrite & pstrb[0];
    assign wr_ctrl   = wr_lane0 & hit_ctrl;
    assign wr_pc     = wr_lane0 & hit_pc;
    assign wr_stat   = wr_lane0 & hit_stat;
    assign wr_mask   = wr_lane0 & hit_mask;
    assign wbyte     = pwdata[7:0];

    // handshake answers
    assign pready    = access_ph;
    assign pslverr   = access_ph & ~hit_any;

    ////////////////////////////////////////////////////////////////////////
    // event detection

    // flags set on their event whatever the enables hold
    assign tof_set   = src_in.timer_overflow;
    assign exf_set   = ext_rise & warm_done;

    // peripheral pending is a level; its rise is the status event
    // a level already high at reset release also counts as a rise
    assign peri_rise = src_in.peripheral_pending & ~peri_prev_q;

    // summary follows the per-pin flags and has no storage
    assign summary   = |pc_flags_q;

    ////////////////////////////////////////////////////////////////////////
    // interrupt_control next value

    // enables load from the bus; flags load too, but a wrap or pin event
    // in the cycle of a clearing write keeps its flag set
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d.global_irq_enable         = wbyte[CIC_B_GIE];
            ctrl_d.peripheral_irq_enable     = wbyte[CIC_B_PERIPHERAL_IRQ_ENABLE];
            ctrl_d.timer_overflow_irq_enable = wbyte[CIC_B_TOIE];
            ctrl_d.ext_pin_irq_enable        = wbyte[CIC_B_EXIE];
            ctrl_d.pin_change_irq_enable     = wbyte[CIC_B_PCIE];
            ctrl_d.timer_overflow_flag       = wbyte[CIC_B_TOF];
            ctrl_d.ext_pin_irq_flag          = wbyte[CIC_B_EXF];
        end
        if (tof_set) begin
            ctrl_d.timer_overflow_flag = 1'b1;
        end
        if (exf_set) begin
            ctrl_d.ext_pin_irq_flag = 1'b1;
        end
        // summary is never stored; writes to it have no effect
        ctrl_d.pin_change_summary_flag = 1'b0;
    end

    // read view substitutes the live summary
    always_comb begin
        ctrl_view                         = ctrl_q;
        ctrl_view.pin_change_summary_flag = summary;
    end

    assign ctrl_out = ctrl_view;

    ////////////////////////////////////////////////////////////////////////
    // per-pin change flags

    // write one clears a pin flag; a change in the same cycle wins
    assign pc_clr     = wr_pc ? wbyte : 8'h00;
    assign pc_flags_d = (pc_flags_q & ~pc_clr) | pc_edge;

    ////////////////////////////////////////////////////////////////////////
    // event status and mask

    // sticky status, write one to clear, a new event wins
    always_comb begin
        evt_set             = '0;
        evt_set[CIC_E_TOV]  = tof_set;
        evt_set[CIC_E_EXT]  = exf_set;
        evt_set[CIC_E_PC]   = |pc_edge;
        evt_set[CIC_E_PERI] = peri_rise;
    end

    assign evt_clr    = wr_stat ? wbyte[3:0] : 4'h0;
    assign evt_stat_d = (evt_stat_q & ~evt_clr) | evt_set;
    assign evt_mask_d = wr_mask ? wbyte[3:0] : evt_mask_q;

    // level interrupt while any unmasked status bit is set
    assign irq_d = |(evt_stat_q & evt_mask_q);

    ////////////////////////////////////////////////////////////////////////
    // core interrupt request

    // each core flag gated by its own enable
    assign req_tmr  = ctrl_q.timer_overflow_irq_enable & ctrl_q.timer_overflow_flag;
    assign req_ext  = ctrl_q.ext_pin_irq_enable & ctrl_q.ext_pin_irq_flag;
    assign req_pc   = ctrl_q.pin_change_irq_enable & summary;

    // the peripheral group passes only with its own enable
    assign req_peri = ctrl_q.peripheral_irq_enable & src_in.peripheral_pending;

    // any enabled cause
    assign core_src_any = req_tmr | req_ext | req_pc | req_peri;

    // global enable blocks or passes all of them
    assign core_irq_d = ctrl_q.global_irq_enable & core_src_any;

    ////////////////////////////////////////////////////////////////////////
    // read data mux, sampled in the setup phase

    // each register view widened to a bus word
    assign rd_ctrl  = {24'h0, ctrl_view};
    assign rd_pc    = {24'h0, pc_flags_q};
    assign rd_stat  = {28'h0, evt_stat_q};
    assign rd_mask  = {28'h0, evt_mask_q};

    // the hits are one-hot; an unmapped address reads zero
    assign rd_word  = ({32{hit_ctrl}} & rd_ctrl) |
                      ({32{hit_pc}}   & rd_pc)   |
                      ({32{hit_stat}} & rd_stat) |
                      ({32{hit_mask}} & rd_mask);

    // loaded in the setup phase, held through the access and after it
    assign prdata_d = setup_ph ? (pwrite ? 32'h0 : rd_word) : prdata_q;

    assign prdata = prdata_q;

    ////////////////////////////////////////////////////////////////////////
    // register file

    // all control state clears on any reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q     <= cic_ctrl_s'(CIC_RST_CTRL);
            pc_flags_q <= CIC_RST_PC_FLAGS;
        end else begin
            ctrl_q     <= ctrl_d;
            pc_flags_q <= pc_flags_d;
        end
    end

    // event status, mask and previous peripheral level
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            evt_stat_q  <= CIC_RST_EVT;
            evt_mask_q  <= CIC_RST_EVT;
            peri_prev_q <= 1'b0;
        end else begin
            evt_stat_q  <= evt_stat_d;
            evt_mask_q  <= evt_mask_d;
            peri_prev_q <= src_in.peripheral_pending;
        end
    end

    // saturating count of edges since reset, gates the pin edge events
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            warm_q <= 2'h0;
        end else begin
            warm_q <= warm_d;
        end
    end

    // registered outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            prdata_q   <= '0;
            core_irq_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            prdata_q   <= prdata_d;
            core_irq_q <= core_irq_d;
            irq_q      <= irq_d;
        end
    end

    assign core_irq_req = core_irq_q;
    assign irq          = irq_q;

endmodule

/* cic_pkg.sv */
/*
 * Shared constants and carriers for the core interrupt control block:
 * register byte offsets, field positions, reset values and the packed
 * structs that carry the control register and the same-clock sources.
 * Assumes a 32-bit APB register bus with a 12-bit byte address.
 */
package cic_pkg;

    // bus geometry
    localparam int unsigned CIC_ADDR_W   = 12;
    localparam int unsigned CIC_DATA_W   = 32;
    localparam int unsigned CIC_REG_W    = 8;
    localparam int unsigned CIC_PC_PINS  = 8;
    localparam int unsigned CIC_EVT_W    = 4;

    // register byte offsets
    localparam logic [11:0] CIC_OFF_CTRL     = 12'h000; // interrupt_control
    localparam logic [11:0] CIC_OFF_PC_FLAGS = 12'h004; // pin_change_pin_flags
    localparam logic [11:0] CIC_OFF_EVT_STAT = 12'h008; // sticky event status
    localparam logic [11:0] CIC_OFF_EVT_MASK = 12'h00c; // event mask

    // interrupt_control field positions
    localparam int unsigned CIC_B_GIE   = 7;
    localparam int unsigned CIC_B_PERIPHERAL_IRQ_ENABLE  = 6;
    localparam int unsigned CIC_B_TOIE  = 5;
    localparam int unsigned CIC_B_EXIE  = 4;
    localparam int unsigned CIC_B_PCIE  = 3;
    localparam int unsigned CIC_B_TOF   = 2;
    localparam int unsigned CIC_B_EXF   = 1;
    localparam int unsigned CIC_B_PCF   = 0;

    // event status field positions
    localparam int unsigned CIC_E_TOV   = 0;
    localparam int unsigned CIC_E_EXT   = 1;
    localparam int unsigned CIC_E_PC    = 2;
    localparam int unsigned CIC_E_PERI  = 3;

    // reset values
    localparam logic [7:0]  CIC_RST_CTRL     = 8'h00;
    localparam logic [7:0]  CIC_RST_PC_FLAGS = 8'h00;
    localparam logic [3:0]  CIC_RST_EVT      = 4'h0;

    // synchroniser depth for pins
    localparam int unsigned CIC_SYNC_STAGES  = 2;

    // interrupt_control layout, bit 7 first
    typedef struct packed {
        logic global_irq_enable;
        logic peripheral_irq_enable;
        logic timer_overflow_irq_enable;
        logic ext_pin_irq_enable;
        logic pin_change_irq_enable;
        logic timer_overflow_flag;
        logic ext_pin_irq_flag;
        logic pin_change_summary_flag;
    } cic_ctrl_s;

    // same-clock event sources
    typedef struct packed {
        logic timer_overflow;    // one-cycle pulse on timer_count_register wrap
        logic peripheral_pending; // level: any enabled peripheral request
    } cic_src_s;

endpackage

/* cic_pin_sync.sv */
/*
 * Two-flop synchroniser with edge detection for a group of pins.
 * Assumes the pins are asynchronous to clock; edges are reported
 * as one-cycle pulses, one to two cycles after the pin moves.
 */
`timescale 1ns/1ps
module cic_pin_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise,
    output logic      [WIDTH-1:0] fall
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] prev_q;

    ////////////////////////////////////////////////////////////////////////
    // first flop feeds only the second one
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // edges of the synchronised level
    assign level = sync_q;
    assign rise  = sync_q & ~prev_q;
    assign fall  = ~sync_q & prev_q;

endmodule

/* cic_props.sv */
/* checker for the core interrupt control block: request gating,
   flag setting and bus answers. assumes one clock and async reset_n. */
`timescale 1ns/1ps
module cic_props (
    input wire logic         clock,
    input wire logic         reset_n,
    input wire logic         psel,
    input wire logic         penable,
    input wire logic [11:0]  paddr,
    input wire logic         pready,
    input wire logic         pslverr,
    input cic_pkg::cic_src_s src_in,
    input wire logic         core_irq_req,
    input cic_pkg::cic_ctrl_s ctrl_out
);
    import cic_pkg::*;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////
    // enabled causes: [3] timer, [2] ext pin, [1] pin change, [0] peripheral
    wire cic_ctrl_s  c = ctrl_out;
    wire logic [3:0] cause = {c.timer_overflow_irq_enable & c.timer_overflow_flag,
        c.ext_pin_irq_enable & c.ext_pin_irq_flag,
        c.pin_change_irq_enable & c.pin_change_summary_flag,
        c.peripheral_irq_enable & src_in.peripheral_pending};
    a_gie_blocks: assert property (
        !$past(c.global_irq_enable) |-> !core_irq_req) else $error("request with gie off");
    a_peripheral_irq_enable_pass: assert property (
        $past(c.global_irq_enable & cause[0]) |-> core_irq_req) else $error("peri lost");
    a_tmr_pass: assert property (
        $past(c.global_irq_enable & cause[3]) |-> core_irq_req) else $error("timer lost");
    a_ext_pass: assert property (
        $past(c.global_irq_enable & cause[2]) |-> core_irq_req) else $error("ext lost");
    a_pc_pass: assert property (
        $past(c.global_irq_enable & cause[1]) |-> core_irq_req) else $error("change lost");
    a_req_cause: assert property (
        core_irq_req |-> $past(c.global_irq_enable && cause != 4'h0)) else $error("stray req");
    a_tov_sets: assert property (
        src_in.timer_overflow |=> c.timer_overflow_flag) else $error("timer flag missed");
    a_ready_access: assert property (
        psel && penable |-> pready) else $error("no ready in access");
    a_unmapped_err: assert property (
        psel && penable && paddr > 12'h00c |-> pslverr) else $error("no error");
endmodule
bind cic_core_irq_ctrl cic_props u_props (.clock, .reset_n, .psel, .penable, .paddr,
    .pready, .pslverr, .src_in, .core_irq_req, .ctrl_out);

/* cic_src_model.sv */
/* event source model: timer wrap pulse, peripheral level and pins.
   assumes its tasks are called from the bench on the same clock. */
`timescale 1ns/1ps
module cic_src_model (
    input  wire logic         clock,
    output cic_pkg::cic_src_s src,
    output logic              ext_pin,
    output logic [7:0]        pc_pins
);
    import cic_pkg::*;
    ////////////////////////////////////////////////////////////
    // quiet sources at time zero
    initial begin
        src = '0;
        ext_pin = 1'b0;
        pc_pins = 8'h00;
    end
    // one-cycle wrap pulse
    task automatic wrap();
        @(posedge clock);
        src.timer_overflow <= 1'b1;
        @(posedge clock);
        src.timer_overflow <= 1'b0;
    endtask
    // peripheral pending level
    task automatic peri(input logic v);
        @(posedge clock);
        src.peripheral_pending <= v;
    endtask
    // toggle pins, then wait out the synchroniser
    task automatic pin_edge(input logic ext, input logic [7:0] pc);
        @(posedge clock);
        ext_pin <= ext_pin ^ ext;
        pc_pins <= pc_pins ^ pc;
        repeat (5) @(posedge clock);
    endtask
endmodule

/* test_core_interrupt_control.sv */
/* self-checking bench for the core interrupt control block over apb.
   assumes the source model beside it; each transfer waits for pready. */
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin err_total++; \
    $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module test_core_interrupt_control;
    import cic_pkg::*;
    logic             clock, reset_n, psel, penable, pwrite, pready, pslverr;
    logic             ext_pin, core_irq_req, irq, rerr;
    logic [11:0]      paddr;
    logic [31:0]      pwdata, prdata, rdat;
    logic [7:0]       pc_pins, en, fl;
    logic [3:0]       pstrb, strb;
    cic_src_s         src;
    cic_ctrl_s        ctrl_o;
    int               err_total, total_checks, cyc;
    ////////////////////////////////////////////////////////////
    // design, source model
    cic_core_irq_ctrl DUT (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .src_in(src), .external_irq_pin(ext_pin), .pin_change_pins(pc_pins),
        .core_irq_req(core_irq_req), .ctrl_out(ctrl_o), .irq(irq));
    cic_src_model src_mdl (.clock(clock), .src(src), .ext_pin(ext_pin), .pc_pins(pc_pins));
    // clock and hang guard
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc++;
        if (cyc > 3000) begin
            err_total++;
            end_of_test();
        end
    end
    // verdict
    task automatic end_of_test();
        if (err_total == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // one apb transfer; data and error taken at the ready edge
    // only the bench timeout ends a wait that never sees pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= strb;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // write control, then look at the request once it has settled
    task automatic wr_chk(input logic [7:0] v, input logic e);
        xfer(1'b1, CIC_OFF_CTRL, {24'h0, v});
        repeat (2) @(negedge clock);
        `CHK(core_irq_req, e)
    endtask
    // main sequence
    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hf;
        strb = 4'hf;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, 12'(4 * i), 32'h0);
            `CHK(rdat, 32'h0)
            `CHK(rerr, i == 4)
        end
        src_mdl.wrap();
        src_mdl.pin_edge(1'b1, 8'h01);
        rd(CIC_OFF_CTRL, 32'h07);
        `CHK(ctrl_o, 8'h07)
        `CHK(core_irq_req, 1'b0)
        rd(CIC_OFF_EVT_STAT, 32'h07);
        xfer(1'b1, CIC_OFF_CTRL, 32'h00);
        rd(CIC_OFF_CTRL, 32'h01);
        src_mdl.pin_edge(1'b0, 8'h80);
        rd(CIC_OFF_PC_FLAGS, 32'h81);
        xfer(1'b1, CIC_OFF_PC_FLAGS, 32'h01);
        rd(CIC_OFF_CTRL, 32'h01);
        xfer(1'b1, CIC_OFF_PC_FLAGS, 32'h80);
        rd(CIC_OFF_CTRL, 32'h00);
        // a write without byte lane 0 is refused
        strb = 4'he;
        xfer(1'b1, CIC_OFF_CTRL, 32'hff);
        strb = 4'hf;
        rd(CIC_OFF_CTRL, 32'h00);
        src_mdl.pin_edge(1'b0, 8'h02);
        for (int i = 0; i < 3; i++) begin
            en = 8'h20 >> i;
            fl = 8'h04 >> i;
            wr_chk(8'h80 | en | fl, 1'b1);
            wr_chk(8'h80 | fl, 1'b0);
            wr_chk(en | fl, 1'b0);
        end
        src_mdl.peri(1'b1);
        wr_chk(8'hc0, 1'b1);
        wr_chk(8'h80, 1'b0);
        wr_chk(8'h40, 1'b0);
        xfer(1'b1, CIC_OFF_EVT_STAT, 32'h0f);
        rd(CIC_OFF_EVT_STAT, 32'h00);
        xfer(1'b1, CIC_OFF_EVT_MASK, 32'h01);
        src_mdl.wrap();
        repeat (2) @(negedge clock);
        `CHK(irq, 1'b1)
        xfer(1'b1, CIC_OFF_EVT_MASK, 32'h00);
        repeat (2) @(negedge clock);
        `CHK(irq, 1'b0)
        xfer(1'b1, CIC_OFF_EVT_MASK, 32'h01);
        xfer(1'b1, CIC_OFF_EVT_STAT, 32'h01);
        repeat (2) @(negedge clock);
        `CHK(irq, 1'b0)
        // reset mid-run with pins held high: no edge may come back from it
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        repeat (4) @(negedge clock);
        `CHK(ctrl_o, 8'h00)
        rd(CIC_OFF_PC_FLAGS, 32'h00);
        rd(CIC_OFF_EVT_MASK, 32'h00);
        end_of_test();
    end
endmodule
